// [rtl/wwd_pkg.sv]
// Package: constants, register map and field layout of the windowed watchdog
package wwd_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] WWD_OFS_SERVICE = 8'h00;
   localparam logic [7:0] WWD_OFS_BITOP   = 8'h04;
   localparam logic [7:0] WWD_OFS_OSCCTL  = 8'h08;
   localparam logic [7:0] WWD_OFS_IMS     = 8'h0C;
   localparam logic [7:0] WWD_OFS_IXS     = 8'h10;
   localparam logic [7:0] WWD_OFS_STATUS  = 8'h14;
   localparam logic [7:0] WWD_OFS_COUNT   = 8'h18;

   // ---------------------------------------------------------------
   // Option byte fields
   // ---------------------------------------------------------------
   localparam int WWD_OPT_LOCK_BIT = 0;
   localparam int WWD_OPT_OVF_LSB  = 1;
   localparam int WWD_OPT_OVF_MSB  = 3;
   localparam int WWD_OPT_EN_BIT   = 4;
   localparam int WWD_OPT_WIN_LSB  = 5;
   localparam int WWD_OPT_WIN_MSB  = 6;

   // ---------------------------------------------------------------
   // Service register values and control fields
   // ---------------------------------------------------------------
   localparam logic [7:0] WWD_KEY        = 8'hAC;
   localparam logic [7:0] WWD_RD_ENABLED = 8'h9A;
   localparam logic [7:0] WWD_RD_DISABLE = 8'h1A;
   localparam int         WWD_OSC_STOP_BIT = 1;

   // Status fields
   localparam int WWD_ST_FLAG    = 0;
   localparam int WWD_ST_CAU_LSB = 1;
   localparam int WWD_ST_CAU_MSB = 3;
   localparam int WWD_ST_RUN     = 4;
   localparam int WWD_ST_OPEN    = 5;
   localparam int WWD_ST_FIRST   = 6;

   // ---------------------------------------------------------------
   // Counter and window geometry
   // ---------------------------------------------------------------
   localparam int          WWD_CNT_W    = 17;
   localparam int          WWD_BASE_EXP = 10;
   localparam logic [1:0]  WWD_WIN_25   = 2'h0;
   localparam logic [1:0]  WWD_WIN_50   = 2'h1;
   localparam logic [1:0]  WWD_WIN_75   = 2'h2;
   localparam logic [15:0] WWD_EXEMPT_LO = 16'hFB00;

   // Memory area reset values: ROM top / high RAM base, expanded RAM base / top
   localparam logic [31:0] WWD_IMS_RST = 32'hF800_8000;
   localparam logic [31:0] WWD_IXS_RST = 32'hF000_F000;

   // Reset cause codes
   localparam logic [2:0] WWD_CAU_NONE   = 3'h0;
   localparam logic [2:0] WWD_CAU_OVF    = 3'h1;
   localparam logic [2:0] WWD_CAU_KEY    = 3'h2;
   localparam logic [2:0] WWD_CAU_CLOSED = 3'h3;
   localparam logic [2:0] WWD_CAU_BITOP  = 3'h4;
   localparam logic [2:0] WWD_CAU_FETCH  = 3'h5;
   localparam logic [2:0] WWD_CAU_DATA   = 3'h6;

   // Option byte is caught this many cycles plus one after reset release
   localparam logic [1:0] WWD_LOAD_CYC = 2'h2;
endpackage

// [rtl/wwd_watchdog.sv]
// Windowed watchdog timer with illegal access detection and Wishbone register slave
`timescale 1ns/1ps
module wwd_watchdog
   import wwd_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Option byte pins and low-speed oscillator
   input  wire logic [7:0]  option_byte_i,
   input  wire logic        lowspeed_clk_i,
   // Processor core status, same clock
   input  wire logic        halt_mode_i,
   input  wire logic        stop_mode_i,
   input  wire logic        self_prog_i,
   input  wire logic        cpu_fetch_i,
   input  wire logic        cpu_read_i,
   input  wire logic        cpu_write_i,
   input  wire logic [15:0] cpu_addr_i,
   // Reset controller
   output logic             wdt_reset_req_o,
   output logic [2:0]       wdt_reset_cause_o,
   output logic             watchdog_reset_cause_flag_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      // Input synchronisers
      logic [7:0]           opt_s1;
      logic [7:0]           opt_s2;
      logic                 ls_s1;
      logic                 ls_s2;
      logic                 ls_s3;
      // Option byte image
      logic [1:0]           load_cnt;
      logic                 loaded;
      logic                 wdt_en;
      logic [2:0]           ovf_sel;
      logic [1:0]           win_sel;
      logic                 osc_lock;
      logic                 osc_stop;
      // Memory area limits
      logic [31:0]          internal_memory_size_register;
      logic [31:0]          expanded_ram_size_register;
      // Counter and service state
      logic [WWD_CNT_W-1:0] cnt;
      logic                 first_done;
      logic                 pend_err;
      logic [2:0]           pend_cause;
      // Reset request and bus
      logic                 rst_req;
      logic [2:0]           cause;
      logic                 flag;
      logic                 ack;
      logic [31:0]          rdata;
   } wwd_state_t;

   wwd_state_t s_reg;
   wwd_state_t s_next;

   // ---------------------------------------------------------------
   // Combinational helpers
   // ---------------------------------------------------------------
   logic                 tick;
   logic                 running;
   logic [WWD_CNT_W:0]   period;
   logic [WWD_CNT_W-1:0] period_m1;
   logic [WWD_CNT_W-1:0] close_lim;
   logic                 win_open;
   logic                 wb_req;
   logic                 wr_hit;
   logic                 fetch_ok;
   logic                 data_ok;

   function automatic logic in_area(input logic [15:0] a,
                                    input logic [31:0] internal_memory_size_register,
                                    input logic [31:0] expanded_ram_size_register);
      logic rom_ok;
      logic ram_ok;
      logic xram_ok;
      // ROM from zero, high RAM to the top, expanded RAM between its limits
      rom_ok  = a < internal_memory_size_register[15:0];
      ram_ok  = a >= internal_memory_size_register[31:16];
      xram_ok = (a >= expanded_ram_size_register[15:0]) && (a < expanded_ram_size_register[31:16]);
      return rom_ok | ram_ok | xram_ok;
   endfunction

   always_comb begin
      // ---------------------------------------------------------------
      // Low-speed tick
      // ---------------------------------------------------------------
      // Edge of the low-speed clock taken from the second and third flops
      tick      = s_reg.ls_s2 & ~s_reg.ls_s3;

      // ---------------------------------------------------------------
      // Count enable
      // ---------------------------------------------------------------
      // Halt, stop and oscillator stop only freeze when the oscillator is not locked
      running   = s_reg.wdt_en & (s_reg.osc_lock
                  | ~(halt_mode_i | stop_mode_i | s_reg.osc_stop));

      // ---------------------------------------------------------------
      // Period and window
      // ---------------------------------------------------------------
      // One bit wider: the longest period would wrap to zero in the count width
      period    = (WWD_CNT_W+1)'(32'h0000_0001 << (WWD_BASE_EXP + 32'(s_reg.ovf_sel)));
      period_m1 = WWD_CNT_W'(period - (WWD_CNT_W+1)'(1));
      unique case (s_reg.win_sel)
         WWD_WIN_25: close_lim = WWD_CNT_W'(period - (period >> 2));
         WWD_WIN_50: close_lim = WWD_CNT_W'(period >> 1);
         WWD_WIN_75: close_lim = WWD_CNT_W'(period >> 2);
         default:    close_lim = '0;
      endcase
      win_open  = s_reg.cnt >= close_lim;

      // ---------------------------------------------------------------
      // Bus and access decode
      // ---------------------------------------------------------------
      wb_req    = wb_cyc_i & wb_stb_i & ~s_reg.ack;
      wr_hit    = wb_req & wb_we_i;
      fetch_ok  = in_area(cpu_addr_i, s_reg.internal_memory_size_register, s_reg.expanded_ram_size_register);
      data_ok   = fetch_ok | (cpu_addr_i >= WWD_EXEMPT_LO);
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic       fire;
      logic [2:0] fire_cause;
      logic       key_err;
      logic [2:0] key_cause;
      logic       clear;
      fire       = 1'b0;
      fire_cause = WWD_CAU_NONE;
      key_err    = 1'b0;
      key_cause  = WWD_CAU_NONE;
      clear      = 1'b0;
      s_next     = s_reg;

      // ---------------------------------------------------------------
      // Input synchronisers
      // ---------------------------------------------------------------
      s_next.opt_s1 = option_byte_i;
      s_next.opt_s2 = s_reg.opt_s1;
      s_next.ls_s1  = lowspeed_clk_i;
      s_next.ls_s2  = s_reg.ls_s1;
      s_next.ls_s3  = s_reg.ls_s2;

      // ---------------------------------------------------------------
      // Option byte
      // ---------------------------------------------------------------
      // Option byte caught once after release; counting then starts on its own
      if (!s_reg.loaded) begin
         if (s_reg.load_cnt == WWD_LOAD_CYC) begin
            s_next.loaded   = 1'b1;
            s_next.wdt_en   = s_reg.opt_s2[WWD_OPT_EN_BIT];
            s_next.ovf_sel  = s_reg.opt_s2[WWD_OPT_OVF_MSB:WWD_OPT_OVF_LSB];
            s_next.win_sel  = s_reg.opt_s2[WWD_OPT_WIN_MSB:WWD_OPT_WIN_LSB];
            s_next.osc_lock = s_reg.opt_s2[WWD_OPT_LOCK_BIT];
         end else begin
            s_next.load_cnt = s_reg.load_cnt + 2'h1;
         end
      end

      // ---------------------------------------------------------------
      // Bus handshake
      // ---------------------------------------------------------------
      // Bus handshake: answer one cycle after the request, drop next cycle
      s_next.ack = wb_req;

      // ---------------------------------------------------------------
      // Service register writes
      // ---------------------------------------------------------------
      if (wr_hit && wb_sel_i[0] && wb_adr_i == WWD_OFS_SERVICE && s_reg.wdt_en) begin
         if (wb_dat_i[7:0] != WWD_KEY) begin
            key_err   = 1'b1;
            key_cause = WWD_CAU_KEY;
         end else if (s_reg.first_done && !win_open) begin
            key_err   = 1'b1;
            key_cause = WWD_CAU_CLOSED;
         end else begin
            clear             = 1'b1;
            s_next.first_done = 1'b1;
         end
      end

      // ---------------------------------------------------------------
      // Bit manipulation
      // ---------------------------------------------------------------
      // Read-modify-write alias models a single-bit instruction
      if (wr_hit && wb_adr_i == WWD_OFS_BITOP && s_reg.wdt_en) begin
         key_err   = 1'b1;
         key_cause = WWD_CAU_BITOP;
      end

      // ---------------------------------------------------------------
      // Deferred key errors
      // ---------------------------------------------------------------
      // A frozen count (halt, stop or oscillator stop with the lock clear) defers the reset until counting resumes
      if (key_err && !running) begin
         s_next.pend_err   = 1'b1;
         s_next.pend_cause = key_cause;
      end else if (key_err) begin
         fire       = 1'b1;
         fire_cause = key_cause;
      end else if (s_reg.pend_err && running) begin
         fire       = 1'b1;
         fire_cause = s_reg.pend_cause;
      end

      // ---------------------------------------------------------------
      // Illegal access detection
      // ---------------------------------------------------------------
      // Illegal access detection follows the enable bit
      if (s_reg.wdt_en && !fire) begin
         if (cpu_fetch_i && !fetch_ok) begin
            fire       = 1'b1;
            fire_cause = WWD_CAU_FETCH;
         end else if ((cpu_read_i || cpu_write_i) && !data_ok) begin
            fire       = 1'b1;
            fire_cause = WWD_CAU_DATA;
         end
      end

      // ---------------------------------------------------------------
      // Counter
      // ---------------------------------------------------------------
      // Counter; a key clear beats an overflow in the same cycle
      if (clear) begin
         s_next.cnt = '0;
      end else if (running && tick) begin
         if (s_reg.cnt == period_m1) begin
            if (!fire) begin
               fire       = 1'b1;
               fire_cause = WWD_CAU_OVF;
            end
         end else begin
            s_next.cnt = s_reg.cnt + WWD_CNT_W'(1);
         end
      end

      // ---------------------------------------------------------------
      // Other registers
      // ---------------------------------------------------------------
      if (wr_hit && wb_adr_i == WWD_OFS_OSCCTL && wb_sel_i[0]) begin
         s_next.osc_stop = wb_dat_i[WWD_OSC_STOP_BIT];
      end
      for (int b = 0; b < 4; b++) begin
         if (wr_hit && wb_sel_i[b] && wb_adr_i == WWD_OFS_IMS) begin
            s_next.internal_memory_size_register[b*8 +: 8] = wb_dat_i[b*8 +: 8];
         end
         if (wr_hit && wb_sel_i[b] && wb_adr_i == WWD_OFS_IXS) begin
            s_next.expanded_ram_size_register[b*8 +: 8] = wb_dat_i[b*8 +: 8];
         end
      end
      if (wr_hit && wb_sel_i[0] && wb_adr_i == WWD_OFS_STATUS
          && wb_dat_i[WWD_ST_FLAG]) begin
         s_next.flag = 1'b0;
      end

      // ---------------------------------------------------------------
      // Reset request
      // ---------------------------------------------------------------
      // Single reset request; record cause and flag, clear the counter, first service and pending error, other registers keep their values
      s_next.rst_req = fire;
      if (fire) begin
         s_next.cause      = fire_cause;
         s_next.flag       = 1'b1;
         s_next.cnt        = '0;
         s_next.first_done = 1'b0;
         s_next.pend_err   = 1'b0;
      end

      // ---------------------------------------------------------------
      // Read data
      // ---------------------------------------------------------------
      s_next.rdata = '0;
      if (wb_req && !wb_we_i) begin
         unique case (wb_adr_i)
            WWD_OFS_SERVICE: begin
               s_next.rdata[7:0] = s_reg.wdt_en ? WWD_RD_ENABLED : WWD_RD_DISABLE;
            end
            WWD_OFS_OSCCTL: begin
               s_next.rdata[WWD_OSC_STOP_BIT] = s_reg.osc_stop;
            end
            WWD_OFS_IMS: begin
               s_next.rdata = s_reg.internal_memory_size_register;
            end
            WWD_OFS_IXS: begin
               s_next.rdata = s_reg.expanded_ram_size_register;
            end
            WWD_OFS_STATUS: begin
               s_next.rdata[WWD_ST_FLAG]                   = s_reg.flag;
               s_next.rdata[WWD_ST_CAU_MSB:WWD_ST_CAU_LSB] = s_reg.cause;
               s_next.rdata[WWD_ST_RUN]                    = running;
               s_next.rdata[WWD_ST_OPEN]                   = win_open;
               s_next.rdata[WWD_ST_FIRST]                  = s_reg.first_done;
            end
            WWD_OFS_COUNT: begin
               s_next.rdata[WWD_CNT_W-1:0] = s_reg.cnt;
            end
            default: begin
               s_next.rdata = '0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_reg      <= '0;
         s_reg.internal_memory_size_register  <= WWD_IMS_RST;
         s_reg.expanded_ram_size_register  <= WWD_IXS_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign wb_dat_o                    = s_reg.rdata;
   assign wb_ack_o                    = s_reg.ack;
   assign wdt_reset_req_o             = s_reg.rst_req;
   assign wdt_reset_cause_o           = s_reg.cause;
   assign watchdog_reset_cause_flag_o = s_reg.flag;

   // ---------------------------------------------------------------
   // Unused inputs
   // ---------------------------------------------------------------
   // Self-programming needs no special handling: counting never pauses for it
   logic unused_ok;
   assign unused_ok = self_prog_i;

endmodule

// [rtl/_unused_placeholder_removed.sv]
// Intentionally empty design file slot
`timescale 1ns/1ps

// [verification/wwd_watchdog_monitor.sv]
// Checker for bus handshake and reset request behaviour of the watchdog
`timescale 1ns/1ps
module wwd_watchdog_monitor
   import wwd_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic [7:0]  option_byte_i,
   input wire logic        wdt_reset_req_o,
   input wire logic [2:0]  wdt_reset_cause_o,
   input wire logic        watchdog_reset_cause_flag_o
);
   // ----------
   // Decode
   // ----------
   logic take;
   logic armed;
   logic en;
   assign take  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign en    = option_byte_i[WWD_OPT_EN_BIT];
   // Lock set only: a frozen count may legally hold a key error back
   assign armed = en & option_byte_i[WWD_OPT_LOCK_BIT];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_take; take |=> wb_ack_o; endproperty
   a_ack_take: assert property (p_ack_take)
      else $error("request not answered in next cycle");
   property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("ack held for two cycles");
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
   a_dat_idle: assert property (p_dat_idle)
      else $error("read data not zero outside ack");
   property p_svc_read; take && !wb_we_i && wb_adr_i == WWD_OFS_SERVICE
      |=> wb_dat_o[7:0] == (en ? WWD_RD_ENABLED : WWD_RD_DISABLE); endproperty
   a_svc_read: assert property (p_svc_read)
      else $error("service read value wrong");
   property p_bad_key; take && wb_we_i && wb_sel_i[0] && armed && wb_adr_i == WWD_OFS_SERVICE
      && wb_dat_i[7:0] != WWD_KEY |=> wdt_reset_req_o && wdt_reset_cause_o == WWD_CAU_KEY;
   endproperty
   a_bad_key: assert property (p_bad_key)
      else $error("wrong key gave no reset");
   property p_bit_op; take && wb_we_i && armed && wb_adr_i == WWD_OFS_BITOP
      |=> wdt_reset_req_o && wdt_reset_cause_o == WWD_CAU_BITOP; endproperty
   a_bit_op: assert property (p_bit_op)
      else $error("bit operation gave no reset");
   property p_req_shape; wdt_reset_req_o |-> watchdog_reset_cause_flag_o
      && wdt_reset_cause_o != WWD_CAU_NONE ##1 !wdt_reset_req_o; endproperty
   a_req_shape: assert property (p_req_shape)
      else $error("reset request without flag or cause");
   property p_cause_kept; !wdt_reset_req_o ##1 !wdt_reset_req_o
      |-> $stable(wdt_reset_cause_o); endproperty
   a_cause_kept: assert property (p_cause_kept)
      else $error("cause changed without request");
   property p_off; !en |-> !wdt_reset_req_o; endproperty
   a_off: assert property (p_off)
      else $error("request while disabled");
endmodule
bind wwd_watchdog wwd_watchdog_monitor wwd_watchdog_monitor_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .option_byte_i(option_byte_i),
   .wdt_reset_req_o(wdt_reset_req_o), .wdt_reset_cause_o(wdt_reset_cause_o),
   .watchdog_reset_cause_flag_o(watchdog_reset_cause_flag_o)
);

// [verification/wwd_core_model.sv]
// Processor core model: fetches, data accesses and power mode levels
`timescale 1ns/1ps
module wwd_core_model (
   input  wire logic        clk_i,
   output logic             fetch_o,
   output logic             read_o,
   output logic             write_o,
   output logic [15:0]      addr_o,
   output logic             halt_o,
   output logic             stop_o,
   output logic             self_prog_o
);
   initial begin
      {fetch_o, read_o, write_o, halt_o, stop_o, self_prog_o} = 6'h00;
      addr_o = 16'h0000;
   end
   // One-cycle strobe; address inverted after release so stale values never match
   task automatic access(input logic [2:0] kind, input logic [15:0] a);
      @(posedge clk_i);
      {fetch_o, read_o, write_o} <= kind;
      addr_o <= a;
      @(posedge clk_i);
      {fetch_o, read_o, write_o} <= 3'h0;
      addr_o <= ~a;
   endtask
   task automatic power(input logic h, input logic s, input logic p);
      @(posedge clk_i);
      {halt_o, stop_o, self_prog_o} <= {h, s, p};
   endtask
endmodule

// [verification/test_wwd_watchdog.sv]
// Self-checking bench for the windowed watchdog
`timescale 1ns/1ps
module test_wwd_watchdog
   import wwd_pkg::*;
;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ls_clk;
   logic [7:0]  wb_adr_i, option_byte_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rdat, c1, hold;
   logic        fetch, rd, wr, halt, stop, prog, req, flag;
   logic [15:0] addr;
   logic [2:0]  cause;
   logic [1:0]  div = 2'h0;
   int          failures, check_count, req_cnt, base, ticks, req_tick, cyc_cnt, t0, d, p;
   wwd_watchdog wwd_watchdog_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .option_byte_i(option_byte_i),
      .lowspeed_clk_i(ls_clk), .halt_mode_i(halt), .stop_mode_i(stop), .self_prog_i(prog),
      .cpu_fetch_i(fetch), .cpu_read_i(rd), .cpu_write_i(wr), .cpu_addr_i(addr),
      .wdt_reset_req_o(req), .wdt_reset_cause_o(cause), .watchdog_reset_cause_flag_o(flag)
   );
   wwd_core_model wwd_core_model_inst (
      .clk_i(clk_i), .fetch_o(fetch), .read_o(rd), .write_o(wr), .addr_o(addr),
      .halt_o(halt), .stop_o(stop), .self_prog_o(prog)
   );
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // ----------
   // Slow clock, tick and request tally, hang limit
   // ----------
   always @(posedge clk_i) begin
      div <= div + 2'h1;
      ls_clk <= div[1];
      if (div == 2'h3) ticks <= ticks + 1;
      if (req === 1'b1) begin
         req_cnt <= req_cnt + 1;
         req_tick <= ticks;
      end
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 90000) begin
         failures++;
         conclude();
      end
   end
   task automatic conclude();
      $display("Checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dat);
      int n;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
      wb_adr_i <= a;
      wb_dat_i <= dat;
      wb_sel_i <= 4'hF;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
      chk("ack edges", 32'h0000_0002, n);
   endtask
   task automatic reset_dut(input logic [7:0] opt);
      @(posedge clk_i);
      rst_i <= 1'b1;
      option_byte_i <= opt;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      base = req_cnt;
   endtask
   task automatic settle(input int n, input logic [2:0] c);
      repeat (8) @(posedge clk_i);
      chk("requests", n, req_cnt - base);
      if (n != 0) chk("cause", {29'h0, c}, {29'h0, cause});
      base = req_cnt;
   endtask
   task automatic moving(input logic e);
      repeat (8) @(posedge clk_i);
      wb(1'b0, WWD_OFS_COUNT, 32'h0);
      c1 = rdat;
      repeat (200) @(posedge clk_i);
      wb(1'b0, WWD_OFS_COUNT, 32'h0);
      chk("count moving", {31'h0, e}, {31'h0, rdat !== c1});
   endtask
   task automatic window_try(input logic [1:0] w, input int off);
      reset_dut({1'b0, w, 1'b1, 3'h1, 1'b1});
      wb(1'b1, WWD_OFS_SERVICE, {24'h0, WWD_KEY});
      t0 = ticks;
      while (ticks - t0 < 2048 * (3 - w) / 4 + off) @(posedge clk_i);
      wb(1'b1, WWD_OFS_SERVICE, {24'h0, WWD_KEY});
      settle(off < 0, WWD_CAU_CLOSED);
   endtask
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0000_0000;
      option_byte_i = 8'h71;
      reset_dut(8'h71);
      wb(1'b0, WWD_OFS_SERVICE, 32'h0);
      chk("service", {24'h0, WWD_RD_ENABLED}, {24'h0, rdat[7:0]});
      wb(1'b0, 8'h1C, 32'h0);
      chk("unmapped", 32'h0000_0000, rdat);
      wb(1'b0, WWD_OFS_IMS, 32'h0);
      chk("size reset", WWD_IMS_RST, rdat);
      wwd_core_model_inst.access(3'h4, 16'h1000);
      wwd_core_model_inst.access(3'h2, 16'hFC00);
      settle(0, WWD_CAU_NONE);
      wb(1'b1, WWD_OFS_IMS, 32'hFF00_8000);
      wwd_core_model_inst.access(3'h2, 16'hFB00);
      settle(0, WWD_CAU_NONE);
      wwd_core_model_inst.access(3'h4, 16'hFB00);
      settle(1, WWD_CAU_FETCH);
      wwd_core_model_inst.access(3'h1, 16'h9000);
      settle(1, WWD_CAU_DATA);
      wb(1'b1, WWD_OFS_BITOP, 32'h0000_00AC);
      settle(1, WWD_CAU_BITOP);
      wb(1'b1, WWD_OFS_SERVICE, 32'h0000_0055);
      settle(1, WWD_CAU_KEY);
      wb(1'b0, WWD_OFS_STATUS, 32'h0);
      chk("status", {28'h0, WWD_CAU_KEY, 1'b1}, {28'h0, rdat[3:0]});
      chk("flag pin", 32'h0000_0001, {31'h0, flag});
      wb(1'b1, WWD_OFS_STATUS, 32'h0000_0001);
      wb(1'b0, WWD_OFS_STATUS, 32'h0);
      chk("flag clear", 32'h0000_0000, {31'h0, rdat[0]});
      chk("flag pin clear", 32'h0000_0000, {31'h0, flag});
      wwd_core_model_inst.power(1'b1, 1'b0, 1'b0);
      moving(1'b1);
      wwd_core_model_inst.power(1'b0, 1'b0, 1'b0);
      reset_dut(8'h70);
      wwd_core_model_inst.power(1'b0, 1'b1, 1'b0);
      moving(1'b0);
      wwd_core_model_inst.power(1'b1, 1'b0, 1'b0);
      moving(1'b0);
      hold = rdat;
      wwd_core_model_inst.power(1'b0, 1'b0, 1'b0);
      moving(1'b1);
      chk("resume", 32'h0000_0001, {31'h0, rdat > hold});
      wb(1'b1, WWD_OFS_OSCCTL, 32'h0000_0002);
      moving(1'b0);
      wb(1'b1, WWD_OFS_OSCCTL, 32'h0000_0000);
      wwd_core_model_inst.power(1'b0, 1'b0, 1'b1);
      moving(1'b1);
      wwd_core_model_inst.power(1'b0, 1'b0, 1'b0);
      reset_dut(8'h60);
      wb(1'b0, WWD_OFS_SERVICE, 32'h0);
      chk("service", {24'h0, WWD_RD_DISABLE}, {24'h0, rdat[7:0]});
      wwd_core_model_inst.access(3'h4, 16'h9000);
      wb(1'b1, WWD_OFS_SERVICE, 32'h0000_0055);
      settle(0, WWD_CAU_NONE);
      moving(1'b0);
      for (int n = 0; n < 2; n++) begin
         reset_dut({4'h7, n[2:0], 1'b1});
         p = 1024 << n;
         while (req_cnt - base < 1) @(posedge clk_i);
         t0 = req_tick;
         while (req_cnt - base < 2) @(posedge clk_i);
         d = req_tick - t0;
         // A restart may slip by up to two slow ticks
         if (d >= p - 2 && d <= p + 2) d = p;
         chk("overflow ticks", p, d);
         chk("cause", {29'h0, WWD_CAU_OVF}, {29'h0, cause});
      end
      for (int w = 0; w < 4; w++) begin
         window_try(w[1:0], 16);
         if (w < 3) window_try(w[1:0], -16);
      end
      conclude();
   end
endmodule
